// file: verilog/twowire_soft_master_hw_slave.sv
// Two-wire interface: software master, hardware slave, transmit FIFO
// Overview of operation
// - Only one of two-wire and SPI may use the shared pins at a time
// - Serial peripheral select low picks two-wire, high picks SPI
// - Offers software-driven master role and hardware-driven slave role
// - Control bit 3 set selects master mode, clear selects slave mode
// - Master data-out bit drives data pin only while drive enable set
// - Drive enable bit 6 makes data pin output when set, input when clear
// - Master clock-out bit 5 drives the clock pin directly
// - With drive enable clear, data pin is latched into bit 4 on clock
// - Interface reset bit 2 holds slave engine in reset while set
// - Hardware sets direction bit 1 when transmitting, clears it receiving
// - Hardware sets byte-done bit 0 after each byte sent or received
// - Byte-done flag clears when software reads the data register
// - Any data register access, read or write, clears byte-done
// - Writing the data register at 9AH supplies the byte to transmit
// - Reading the data register returns the last byte received
// - Address register at 9BH holds 7-bit address, resets to 55H
// - Control register at E8H resets to 00H and is bit addressable
`default_nettype none

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rp_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : tx_fifo

module twowire_soft_master_hw_slave #(
    parameter int FIFO_DEPTH = twi_pkg::TX_FIFO_DEPTH
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       link_clk_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       sfr_bit_wr_i,
    input  wire logic [2:0] sfr_bit_sel_i,
    input  wire logic       sfr_bit_val_i,
    output logic      [7:0] sfr_rdata_o,
    output logic            tx_space_o,
    input  wire logic       serial_peripheral_select_i,
    input  wire logic       serial_clock_pin_i,
    output logic            serial_clock_pin_o,
    output logic            serial_clock_pin_oe_n_o,
    input  wire logic       serial_data_pin_i,
    output logic            serial_data_pin_o,
    output logic            serial_data_pin_oe_n_o
);
    logic [7:0] ctrl_q;
    logic [7:0] own_addr_q;
    logic [7:0] rx_data_q;
    logic       mdi_q;
    logic       done_q;
    logic       dir_q;
    logic       slv_en_q;
    logic [1:0] scl_m_q;
    logic [1:0] sda_m_q;
    logic       scl_m_prev_q;
    logic [2:0] done_t_m_q;
    logic [1:0] dir_m_q;
    logic [1:0] drv_m_q;
    logic [2:0] ack_t_m_q;
    logic [7:0] hold_q;
    logic       hold_full_q;
    logic       req_t_q;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       data_wr;
    logic       data_acc;
    logic       byte_evt;
    logic       scl_rise_m;
    logic       master;
    logic [7:0] ctrl_wr_val;
    logic [7:0] rx_byte_l_q;
    logic       drv_l_q;
    logic       dir_l_q;
    logic       done_t_l_q;
    logic       ack_t_l_q;

    // Shared pins belong to SPI while its select bit is high
    assign master     = ctrl_q[twi_pkg::MSEL_BIT]
                        && !serial_peripheral_select_i;
    assign data_wr    = sfr_wr_i && sfr_addr_i == twi_pkg::DATA_ADDR;
    assign data_acc   = (sfr_wr_i || sfr_rd_i)
                        && sfr_addr_i == twi_pkg::DATA_ADDR;
    assign byte_evt   = done_t_m_q[2] ^ done_t_m_q[1];
    assign scl_rise_m = scl_m_q[1] && !scl_m_prev_q;

    always_comb begin
        ctrl_wr_val = ctrl_q;
        if (sfr_bit_wr_i && sfr_addr_i == twi_pkg::CTRL_ADDR) begin
            ctrl_wr_val[sfr_bit_sel_i] = sfr_bit_val_i;
        end else if (sfr_wr_i && sfr_addr_i == twi_pkg::CTRL_ADDR) begin
            ctrl_wr_val = sfr_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q     <= twi_pkg::CTRL_RST;
            own_addr_q <= twi_pkg::OWN_ADDR_RST;
        end else begin
            ctrl_q <= ctrl_wr_val;
            if (sfr_wr_i && sfr_addr_i == twi_pkg::OWN_ADDR_ADDR) begin
                own_addr_q <= sfr_wdata_i;
            end
        end
    end

    // Hardware-owned bits: an event in the clearing cycle still sets
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            done_q    <= 1'b0;
            rx_data_q <= twi_pkg::DATA_RST;
        end else begin
            if (byte_evt) begin
                done_q <= 1'b1;
                if (!dir_m_q[1]) begin
                    rx_data_q <= rx_byte_l_q;
                end
            end else if (data_acc) begin
                done_q <= 1'b0;
            end else if (sfr_bit_wr_i && sfr_addr_i == twi_pkg::CTRL_ADDR
                         && sfr_bit_sel_i == 3'(twi_pkg::DONE_BIT)) begin
                done_q <= sfr_bit_val_i;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // Idle bus is high: no false clock rise after reset
            scl_m_q      <= 2'h3;
            sda_m_q      <= 2'h3;
            scl_m_prev_q <= 1'b1;
            done_t_m_q   <= 3'h0;
            dir_m_q      <= 2'h0;
            drv_m_q      <= 2'h0;
            ack_t_m_q    <= 3'h0;
        end else begin
            scl_m_q      <= {scl_m_q[0], serial_clock_pin_i};
            sda_m_q      <= {sda_m_q[0], serial_data_pin_i};
            scl_m_prev_q <= scl_m_q[1];
            done_t_m_q   <= {done_t_m_q[1:0], done_t_l_q};
            dir_m_q      <= {dir_m_q[0], dir_l_q};
            drv_m_q      <= {drv_m_q[0], drv_l_q};
            ack_t_m_q    <= {ack_t_m_q[1:0], ack_t_l_q};
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mdi_q    <= 1'b0;
            dir_q    <= 1'b0;
            slv_en_q <= 1'b0;
        end else begin
            if (master && !ctrl_q[twi_pkg::MDE_BIT] && scl_rise_m) begin
                mdi_q <= sda_m_q[1];
            end
            dir_q    <= dir_m_q[1];
            slv_en_q <= !ctrl_q[twi_pkg::MSEL_BIT]
                        && !ctrl_q[twi_pkg::IRST_BIT]
                        && !serial_peripheral_select_i;
        end
    end

    // Pin drivers: master push-pull, slave only pulls data low
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_clock_pin_o      <= 1'b1;
            serial_clock_pin_oe_n_o <= 1'b1;
            serial_data_pin_o       <= 1'b1;
            serial_data_pin_oe_n_o  <= 1'b1;
        end else if (serial_peripheral_select_i) begin
            serial_clock_pin_oe_n_o <= 1'b1;
            serial_data_pin_oe_n_o  <= 1'b1;
        end else if (master) begin
            serial_clock_pin_o      <= ctrl_q[twi_pkg::MCO_BIT];
            serial_clock_pin_oe_n_o <= 1'b0;
            serial_data_pin_o       <= ctrl_q[twi_pkg::MDO_BIT];
            serial_data_pin_oe_n_o  <= !ctrl_q[twi_pkg::MDE_BIT];
        end else begin
            serial_clock_pin_oe_n_o <= 1'b1;
            serial_data_pin_o       <= 1'b0;
            serial_data_pin_oe_n_o  <= !(drv_m_q[1] && slv_en_q);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
            tx_space_o  <= 1'b0;
        end else begin
            tx_space_o <= fifo_in_ready;
            if (sfr_rd_i) begin
                case (sfr_addr_i)
                    twi_pkg::DATA_ADDR:     sfr_rdata_o <= rx_data_q;
                    twi_pkg::OWN_ADDR_ADDR: sfr_rdata_o <= own_addr_q;
                    twi_pkg::CTRL_ADDR:
                        sfr_rdata_o <= {ctrl_q[7:5], mdi_q, ctrl_q[3:2],
                                        dir_q, done_q};
                    default:                sfr_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // A write while the FIFO is full is dropped; tx_space_o shows full one cycle late
    tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (data_wr),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (sfr_wdata_i),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (!hold_full_q),
        .out_data_o  (fifo_out_data)
    );

    // Hold word stays stable until the link side acknowledges it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_q      <= 8'h00;
            hold_full_q <= 1'b0;
            req_t_q     <= 1'b0;
        end else if (!hold_full_q) begin
            if (fifo_out_valid) begin
                hold_q      <= fifo_out_data;
                hold_full_q <= 1'b1;
                req_t_q     <= !req_t_q;
            end
        end else if (ack_t_m_q[2] ^ ack_t_m_q[1]) begin
            hold_full_q <= 1'b0;
        end
    end

    // Link domain: slave engine oversamples the bus
    typedef enum {L_IDLE, L_ADDR, L_AACK, L_RX, L_RACK, L_TX, L_TACK} lst_e;
    lst_e       lst_q;
    logic [1:0] scl_l_q;
    logic [1:0] sda_l_q;
    logic       scl_lp_q;
    logic       sda_lp_q;
    logic [1:0] en_l_q;
    logic [2:0] req_l_q;
    logic [13:0] addr_l_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_sh_q;
    logic       have_q;
    logic       ackon_q;
    logic       tx_load;
    logic       scl_r;
    logic       scl_f;
    logic       start_c;
    logic       stop_c;

    assign scl_r   = scl_l_q[1] && !scl_lp_q;
    assign scl_f   = !scl_l_q[1] && scl_lp_q;
    assign start_c = scl_l_q[1] && scl_lp_q && sda_lp_q && !sda_l_q[1];
    assign stop_c  = scl_l_q[1] && scl_lp_q && !sda_lp_q && sda_l_q[1];
    // A byte starts at the fall ending the address ack or the master ack
    assign tx_load = scl_f && en_l_q[1]
                     && ((lst_q == L_AACK && ackon_q && dir_l_q)
                         || (lst_q == L_TX && cnt_q == 3'h0 && !ackon_q));

    // Address bits are synced per bit; change it only with the slave idle
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_l_q  <= 2'h3;
            sda_l_q  <= 2'h3;
            scl_lp_q <= 1'b1;
            sda_lp_q <= 1'b1;
            en_l_q   <= 2'h0;
            req_l_q  <= 3'h0;
            addr_l_q <= 14'h0;
        end else begin
            scl_l_q  <= {scl_l_q[0], serial_clock_pin_i};
            sda_l_q  <= {sda_l_q[0], serial_data_pin_i};
            scl_lp_q <= scl_l_q[1];
            sda_lp_q <= sda_l_q[1];
            en_l_q   <= {en_l_q[0], slv_en_q};
            req_l_q  <= {req_l_q[1:0], req_t_q};
            addr_l_q <= {addr_l_q[6:0], own_addr_q[6:0]};
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            have_q    <= 1'b0;
            ack_t_l_q <= 1'b0;
            tx_sh_q   <= twi_pkg::IDLE_TX_BYTE;
        end else if (req_l_q[2] ^ req_l_q[1]) begin
            have_q <= 1'b1;
        end else if (tx_load) begin
            // Top bit goes out at once, so store the rest pre-shifted
            tx_sh_q   <= have_q ? {hold_q[6:0], 1'b1} : twi_pkg::IDLE_TX_BYTE;
            have_q    <= 1'b0;
            ack_t_l_q <= ack_t_l_q ^ have_q;
        end else if (lst_q == L_TX && scl_f) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b1};
        end
    end

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lst_q       <= L_IDLE;
            cnt_q       <= 3'h0;
            sh_q        <= 8'h00;
            rx_byte_l_q <= 8'h00;
            ackon_q     <= 1'b0;
            drv_l_q     <= 1'b0;
            dir_l_q     <= 1'b0;
            done_t_l_q  <= 1'b0;
        end else if (!en_l_q[1]) begin
            lst_q   <= L_IDLE;
            drv_l_q <= 1'b0;
            ackon_q <= 1'b0;
        end else if (start_c) begin
            lst_q   <= L_ADDR;
            cnt_q   <= 3'h0;
            drv_l_q <= 1'b0;
            ackon_q <= 1'b0;
        end else if (stop_c) begin
            lst_q   <= L_IDLE;
            drv_l_q <= 1'b0;
        end else begin
            case (lst_q)
                L_ADDR, L_RX: begin
                    if (scl_r) begin
                        sh_q  <= {sh_q[6:0], sda_l_q[1]};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7 && lst_q == L_RX) begin
                            rx_byte_l_q <= {sh_q[6:0], sda_l_q[1]};
                            dir_l_q     <= 1'b0;
                            done_t_l_q  <= !done_t_l_q;
                            lst_q       <= L_RACK;
                        end else if (cnt_q == 3'h7) begin
                            if (sh_q[6:0] == addr_l_q[13:7]) begin
                                dir_l_q <= sda_l_q[1];
                                lst_q   <= L_AACK;
                            end else begin
                                lst_q <= L_IDLE;
                            end
                        end
                    end
                end
                L_AACK, L_RACK: begin
                    if (scl_f && !ackon_q) begin
                        drv_l_q <= 1'b1;
                        ackon_q <= 1'b1;
                    end else if (scl_f) begin
                        ackon_q <= 1'b0;
                        drv_l_q <= 1'b0;
                        cnt_q   <= 3'h0;
                        if (lst_q == L_AACK && dir_l_q) begin
                            lst_q   <= L_TX;
                            drv_l_q <= have_q ? !hold_q[7] : 1'b0;
                        end else begin
                            lst_q <= L_RX;
                        end
                    end
                end
                L_TX: begin
                    if (scl_f && cnt_q == 3'h0 && ackon_q) begin
                        lst_q   <= L_TACK;
                        drv_l_q <= 1'b0;
                    end else if (scl_f && cnt_q == 3'h0) begin
                        drv_l_q <= have_q ? !hold_q[7] : 1'b0;
                    end else if (scl_f) begin
                        drv_l_q <= !tx_sh_q[7];
                    end
                    if (scl_r) begin
                        cnt_q   <= cnt_q + 3'h1;
                        ackon_q <= (cnt_q == 3'h7);
                    end
                end
                L_TACK: begin
                    ackon_q <= 1'b0;
                    if (scl_r) begin
                        done_t_l_q <= !done_t_l_q;
                        lst_q      <= sda_l_q[1] ? L_IDLE : L_TX;
                    end
                end
                default: lst_q <= L_IDLE;
            endcase
        end
    end

    property p_spi_quiet;
        @(posedge mclk_i) disable iff (rst_i)
        serial_peripheral_select_i
        |=> serial_clock_pin_oe_n_o && serial_data_pin_oe_n_o;
    endproperty
    a_spi_quiet: assert property (p_spi_quiet)
        else $error("Pins driven while SPI owns them");

    property p_data_drive;
        @(posedge mclk_i) disable iff (rst_i)
        master |=> serial_data_pin_oe_n_o == !$past(ctrl_q[6])
                   && serial_data_pin_o == $past(ctrl_q[7]);
    endproperty
    a_data_drive: assert property (p_data_drive)
        else $error("Data pin not following master bits");

    property p_clock_drive;
        @(posedge mclk_i) disable iff (rst_i)
        master |=> !serial_clock_pin_oe_n_o
                   && serial_clock_pin_o == $past(ctrl_q[5]);
    endproperty
    a_clock_drive: assert property (p_clock_drive)
        else $error("Clock pin not following clock-out bit");

    property p_mdi_latch;
        @(posedge mclk_i) disable iff (rst_i)
        master && !ctrl_q[6] && scl_rise_m |=> mdi_q == $past(sda_m_q[1]);
    endproperty
    a_mdi_latch: assert property (p_mdi_latch)
        else $error("Data-in bit not latched on clock rise");

    property p_slave_hold;
        @(posedge mclk_i) disable iff (rst_i)
        ctrl_q[2] || ctrl_q[3] |=> !slv_en_q;
    endproperty
    a_slave_hold: assert property (p_slave_hold)
        else $error("Slave enabled in reset or master mode");

    property p_done_set;
        @(posedge mclk_i) disable iff (rst_i)
        byte_evt |=> done_q ##1 (done_q || $past(data_acc, 1));
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("Byte-done flag not set by event");

    property p_done_clear;
        @(posedge mclk_i) disable iff (rst_i)
        data_acc && !byte_evt |=> !done_q;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("Data access did not clear byte-done");

    property p_addr_write;
        @(posedge mclk_i) disable iff (rst_i)
        sfr_wr_i && sfr_addr_i == twi_pkg::OWN_ADDR_ADDR
        |=> own_addr_q == $past(sfr_wdata_i) ##1 sfr_rd_i
            && sfr_addr_i == twi_pkg::OWN_ADDR_ADDR && !sfr_wr_i
        |=> sfr_rdata_o == own_addr_q;
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("Address register write or readback wrong");

    property p_data_read;
        @(posedge mclk_i) disable iff (rst_i)
        sfr_rd_i && sfr_addr_i == twi_pkg::DATA_ADDR
        |=> sfr_rdata_o == $past(rx_data_q);
    endproperty
    a_data_read: assert property (p_data_read)
        else $error("Data read not returning received byte");
endmodule : twowire_soft_master_hw_slave
`default_nettype wire

// file: verilog/twi_pkg.sv
// Register map, field positions and reset values of the two-wire block
`default_nettype none
package twi_pkg;
    localparam logic [7:0] DATA_ADDR     = 8'h9a;
    localparam logic [7:0] OWN_ADDR_ADDR = 8'h9b;
    localparam logic [7:0] CTRL_ADDR     = 8'he8;
    localparam logic [7:0] DATA_RST      = 8'h00;
    localparam logic [7:0] OWN_ADDR_RST  = 8'h55;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam int MDO_BIT   = 7;
    localparam int MDE_BIT   = 6;
    localparam int MCO_BIT   = 5;
    localparam int MDI_BIT   = 4;
    localparam int MSEL_BIT  = 3;
    localparam int IRST_BIT  = 2;
    localparam int DIR_BIT   = 1;
    localparam int DONE_BIT  = 0;
    localparam logic [7:0] IDLE_TX_BYTE = 8'hff;
    localparam int TX_FIFO_DEPTH = 8;
endpackage : twi_pkg
`default_nettype wire

// file: tb/twi_partner.sv
// External two-wire bus master driving the slave engine
`default_nettype none
module twi_partner (
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Open-drain outputs: 1 releases the line to its pull-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic hb;
        repeat (5) @(posedge lclk_i);
    endtask : hb
    // Lines change by non-blocking update, clear of the sampling edges
    task automatic start;
        sda_o <= 1'b0;
        hb();
        scl_o <= 1'b0;
    endtask : start
    task automatic stop;
        hb();
        sda_o <= 1'b0;
        hb();
        scl_o <= 1'b1;
        hb();
        sda_o <= 1'b1;
        hb();
    endtask : stop
    // Data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        hb();
        sda_o <= b;
        hb();
        scl_o <= 1'b1;
        hb();
        r = sda_i;
        scl_o <= 1'b0;
    endtask : bit_x
    task automatic xfer(input logic [7:0] d, input logic ack,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
        bit_x(ack, a);
    endtask : xfer
endmodule : twi_partner
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the two-wire block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_i = 0, rst_i = 1, lclk = 0, spi = 0;
    logic       wr = 0, rd = 0, bwr = 0, bval = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [2:0] bsel = 3'h0;
    logic       space, c_o, c_n, d_o, d_n, p_scl, p_sda;
    wire logic  scl_w = p_scl & (c_n | c_o);
    wire logic  sda_w = p_sda & (d_n | d_o);
    int         n_errors = 0, samples_checked = 0;
    always #5 mclk_i = ~mclk_i;
    // Offset start keeps the link clock out of phase with the core
    initial begin
        #13;
        forever #32 lclk = ~lclk;
    end
    twowire_soft_master_hw_slave #(.FIFO_DEPTH(8))
        u_twowire_soft_master_hw_slave (
        .mclk_i(mclk_i), .rst_i(rst_i), .link_clk_i(lclk),
        .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd),
        .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval),
        .sfr_rdata_o(rdata), .tx_space_o(space),
        .serial_peripheral_select_i(spi),
        .serial_clock_pin_i(scl_w), .serial_clock_pin_o(c_o),
        .serial_clock_pin_oe_n_o(c_n), .serial_data_pin_i(sda_w),
        .serial_data_pin_o(d_o), .serial_data_pin_oe_n_o(d_n));
    twi_partner u_twi_partner (.lclk_i(lclk), .sda_i(sda_w),
        .scl_o(p_scl), .sda_o(p_sda));
    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [7:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge mclk_i);
        addr = a; wd = d; wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask : wr_reg
    task automatic bit_wr(input logic [2:0] s, input logic v);
        @(negedge mclk_i);
        addr = twi_pkg::CTRL_ADDR; bsel = s; bval = v; bwr = 1'b1;
        @(negedge mclk_i);
        bwr = 1'b0;
    endtask : bit_wr
    task automatic chk_reg(input string w, input logic [7:0] a, m, e);
        @(negedge mclk_i);
        addr = a; rd = 1'b1;
        @(negedge mclk_i);
        rd = 1'b0;
        @(negedge mclk_i);
        chk(w, e, rdata & m);
    endtask : chk_reg
    task automatic open_frame(input logic [7:0] ab, output logic a);
        logic [7:0] r;
        u_twi_partner.start();
        u_twi_partner.xfer(ab, 1'b1, r, a);
    endtask : open_frame
    task automatic t_reset;
        chk_reg("data", twi_pkg::DATA_ADDR, 8'hff, 8'h00);
        chk_reg("own", twi_pkg::OWN_ADDR_ADDR, 8'hff, 8'h55);
        chk_reg("ctrl", twi_pkg::CTRL_ADDR, 8'hff, 8'h00);
        chk_reg("unmapped", 8'h9c, 8'hff, 8'h00);
        chk("space", 8'h01, {7'h0, space});
    endtask : t_reset
    task automatic t_master;
        wr_reg(twi_pkg::CTRL_ADDR, 8'h68);
        cyc(3);
        chk("pins", 8'h08, {4'h0, c_o, c_n, d_o, d_n});
        wr_reg(twi_pkg::CTRL_ADDR, 8'ha8);
        cyc(3);
        chk("drive off", 8'h05, {5'h0, c_o, c_n, d_n});
        for (int v = 0; v < 2; v++) begin
            u_twi_partner.sda_o <= v[0];
            bit_wr(3'h5, 1'b0);
            cyc(8);
            bit_wr(3'h5, 1'b1);
            cyc(8);
            chk_reg("data in", twi_pkg::CTRL_ADDR, 8'h10, {3'h0, v[0], 4'h0});
        end
        wr_reg(twi_pkg::CTRL_ADDR, 8'h68);
        spi = 1'b1;
        cyc(3);
        chk("spi owns", 8'h03, {6'h0, c_n, d_n});
        spi = 1'b0;
        wr_reg(twi_pkg::CTRL_ADDR, 8'h00);
        cyc(10);
    endtask : t_master
    task automatic t_rx;
        logic a;
        logic [7:0] r;
        open_frame(8'haa, a);
        chk("addr ack", 8'h00, {7'h0, a});
        u_twi_partner.xfer(8'ha5, 1'b1, r, a);
        chk("data ack", 8'h00, {7'h0, a});
        u_twi_partner.stop();
        cyc(20);
        chk_reg("rx flags", twi_pkg::CTRL_ADDR, 8'h03, 8'h01);
        chk_reg("rx data", twi_pkg::DATA_ADDR, 8'hff, 8'ha5);
        chk_reg("done", twi_pkg::CTRL_ADDR, 8'h01, 8'h00);
    endtask : t_rx
    task automatic t_tx;
        logic a;
        logic [7:0] r;
        wr_reg(twi_pkg::DATA_ADDR, 8'h3c);
        open_frame(8'hab, a);
        chk("addr ack", 8'h00, {7'h0, a});
        u_twi_partner.xfer(8'hff, 1'b1, r, a);
        chk("tx byte", 8'h3c, r);
        cyc(20);
        chk_reg("tx flags", twi_pkg::CTRL_ADDR, 8'h03, 8'h03);
        wr_reg(twi_pkg::DATA_ADDR, 8'h00);
        chk_reg("done", twi_pkg::CTRL_ADDR, 8'h01, 8'h00);
        u_twi_partner.stop();
    endtask : t_tx
    task automatic t_refuse;
        logic a;
        logic [7:0] ab [3] = '{8'ha8, 8'haa, 8'h42};
        for (int k = 0; k < 3; k++) begin
            if (k == 1) bit_wr(3'h2, 1'b1);
            if (k == 2) begin
                bit_wr(3'h2, 1'b0);
                wr_reg(twi_pkg::OWN_ADDR_ADDR, 8'h21);
                chk_reg("own", twi_pkg::OWN_ADDR_ADDR, 8'hff, 8'h21);
            end
            open_frame(ab[k], a);
            chk("ack", {7'h0, k != 2}, {7'h0, a});
            u_twi_partner.stop();
        end
        wr_reg(twi_pkg::OWN_ADDR_ADDR, 8'h55);
    endtask : t_refuse
    // Hold word plus eight queued fill the path; a ninth write is dropped
    task automatic t_fifo;
        logic a;
        logic [7:0] r;
        logic [7:0] e;
        for (int i = 0; i < 8; i++) wr_reg(twi_pkg::DATA_ADDR, 8'(8'h10 + i));
        cyc(2);
        chk("full", 8'h00, {7'h0, space});
        wr_reg(twi_pkg::DATA_ADDR, 8'h99);
        open_frame(8'hab, a);
        for (int i = 0; i < 10; i++) begin
            u_twi_partner.xfer(8'hff, i == 9, r, a);
            e = (i == 0) ? 8'h00 : (i == 9) ? 8'hff : 8'(8'h0f + i);
            chk("fifo out", e, r);
        end
        u_twi_partner.stop();
        cyc(3);
        chk("empty", 8'h01, {7'h0, space});
    endtask : t_fifo
    // Reset spans two link edges as well, longer than four core cycles
    initial begin
        cyc(4);
        repeat (2) @(posedge lclk);
        @(negedge mclk_i);
        rst_i = 1'b0;
        cyc(2);
        t_reset();
        t_master();
        t_rx();
        t_tx();
        t_refuse();
        t_fifo();
        report_and_stop();
    end
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
